// ---- dv/osc_tick_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module osc_tick_model (
	input wire logic core_clk,
	input wire logic arst_n,
	output logic osc_tick
);
	// half-rate ticks so the cycle count cannot lean on one tick per clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_tick <= 1'b0;
		end else begin
			osc_tick <= ~osc_tick;
		end
	end
endmodule // osc_tick_model
`default_nettype wire

// ---- dv/tb_scan_timing_buffer_ctrl_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("Error %0t got %h exp %h", $time, a, b); end end
module tb_scan_timing_buffer_ctrl_regs import scan_regs_pkg::*;;
	logic core_clk, arst_n = 0, gc_reset = 0, dev_reset = 0;
	logic autoseq_en = 0, seq_fault = 0;
	reg_req_t req = '0;
	sample_t sample = '0;
	logic [7:0] rdata, cycle_clocks_eff, v, mn, n;
	logic rvalid, osc_tick, busy_pin, conv_start, conv_done, osc_select;
	logic [2:0] fill_policy;
	logic [15:0] buf_word, w;
	logic buf_word_stb;
	logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
	int failures = 0, comparisons = 0, i;
	osc_tick_model osc_tick_model_inst (.core_clk(core_clk),
		.arst_n(arst_n), .osc_tick(osc_tick));
	scan_timing_buffer_ctrl_regs scan_timing_buffer_ctrl_regs_inst (
		.core_clk(core_clk), .arst_n(arst_n), .gc_reset(gc_reset),
		.dev_reset(dev_reset), .req(req), .rdata(rdata), .rvalid(rvalid),
		.osc_tick(osc_tick), .autoseq_en(autoseq_en),
		.seq_fault(seq_fault), .sample(sample), .busy_pin(busy_pin),
		.conv_start(conv_start), .conv_done(conv_done),
		.osc_select(osc_select), .cycle_clocks_eff(cycle_clocks_eff),
		.fill_policy(fill_policy), .buf_word(buf_word),
		.buf_word_stb(buf_word_stb));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic final_report;
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// a free edge before each strobe keeps back-to-back calls legal
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1 req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(posedge core_clk);
		#1 req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		#1 req.rd = 1'b1;
		req.addr = a;
		@(posedge core_clk);
		#1 req.rd = 1'b0;
		`chk(rvalid, 1'b1)
		`chk(rdata, e)
	endtask
	task automatic pulse(input int which);
		@(posedge core_clk);
		#1 if (which == 0) gc_reset = 1'b1; else dev_reset = 1'b1;
		@(posedge core_clk);
		#1 gc_reset = 1'b0;
		dev_reset = 1'b0;
	endtask
	initial begin
		#100000;
		failures++;
		final_report;
	end
	initial begin
		repeat (10) @(posedge core_clk);
		#1 arst_n = 1'b1;
		`chk(fill_policy, buffer_fill_policy_rst)
		`chk(busy_pin, 1'b0)
		rd(scan_error_state_off, zero_byte);
		rd(oscillator_choice_off, oscillator_choice_rst);
		rd(conv_cycle_clocks_off, conv_cycle_clocks_rst);
		rd(word_layout_off, {6'h0, word_layout_rst});
		rd(buffer_fill_policy_off, {5'h0, buffer_fill_policy_rst});
		rd(scan_cancel_off, zero_byte);
		rd(8'h55, zero_byte);
		`chk(cycle_clocks_eff, 8'h15)
		wr(scan_error_state_off, 8'hff);
		rd(scan_error_state_off, zero_byte);
		for (i = 0; i < 2; i++) begin
			wr(oscillator_choice_off, i[7:0]);
			`chk(osc_select, i[0])
			mn = i[0] ? 8'h12 : 8'h15;
			// sweep across both minimum boundaries
			for (v = 8'h10; v < 8'h18; v++) begin
				wr(conv_cycle_clocks_off, v);
				`chk(cycle_clocks_eff, (v > mn) ? v : mn)
			end
		end
		for (i = 0; i < 4; i++) begin
			wr(buffer_fill_policy_off, {5'h0, codes[i]});
			`chk(fill_policy, codes[i])
			rd(buffer_fill_policy_off, {5'h0, codes[i]});
		end
		sample = '{result: 12'habc, chan: 1'b1, valid_flag: 1'b1,
			stb: 1'b0};
		for (i = 0; i < 4; i++) begin
			wr(word_layout_off, i[7:0]);
			rd(word_layout_off, i[7:0]);
			@(posedge core_clk);
			#1 sample.stb = 1'b1;
			@(posedge core_clk);
			#1 sample.stb = 1'b0;
			`chk(buf_word_stb, 1'b1)
			w = (i == 1) ? 16'habc2 :
				(i == 2) ? 16'habc3 : 16'habc0;
			`chk(buf_word, w)
		end
		autoseq_en = 1'b1;
		wr(scan_launch_off, 8'h01);
		`chk(busy_pin, 1'b1)
		`chk(conv_start, 1'b1)
		// ticks seen before each edge are summed until the cycle ends
		n = 8'h00;
		for (i = 0; i < 200 && conv_done !== 1'b1; i++) begin
			n = n + {7'h0, osc_tick};
			#10;
		end
		`chk(conv_done, 1'b1)
		`chk(n, 8'h17)
		rd(scan_error_state_off, 8'h02);
		seq_fault = 1'b1;
		rd(scan_error_state_off, 8'h06);
		wr(scan_cancel_off, 8'hfe);
		`chk(busy_pin, 1'b1)
		wr(scan_cancel_off, 8'h01);
		`chk(busy_pin, 1'b0)
		rd(scan_error_state_off, 8'h06);
		autoseq_en = 1'b0;
		seq_fault = 1'b0;
		rd(scan_error_state_off, zero_byte);
		wr(oscillator_choice_off, 8'h01);
		wr(scan_launch_off, 8'h01);
		pulse(0);
		`chk(busy_pin, 1'b0)
		`chk(osc_select, 1'b0)
		wr(buffer_fill_policy_off, 8'h00);
		pulse(1);
		`chk(fill_policy, 3'h1)
		final_report;
	end
endmodule // tb_scan_timing_buffer_ctrl_regs
`default_nettype wire

// ---- hw/scan_regs_pkg.sv ----
package scan_regs_pkg;
	localparam logic [7:0] scan_error_state_off = 8'h04;
	localparam logic [7:0] oscillator_choice_off = 8'h18;
	localparam logic [7:0] conv_cycle_clocks_off = 8'h19;
	localparam logic [7:0] scan_launch_off = 8'h1e;
	localparam logic [7:0] scan_cancel_off = 8'h1f;
	localparam logic [7:0] word_layout_off = 8'h28;
	localparam logic [7:0] buffer_fill_policy_off = 8'h2c;
	localparam logic [7:0] zero_byte = 8'h00;
	localparam logic [7:0] oscillator_choice_rst = 8'h00;
	localparam logic [7:0] conv_cycle_clocks_rst = 8'h00;
	localparam logic [1:0] word_layout_rst = 2'h0;
	localparam logic [2:0] buffer_fill_policy_rst = 3'h1;
	localparam int launch_bit = 0;
	localparam int cancel_bit = 0;
	localparam int osc_bit = 0;
	localparam int err_lo = 1;
	localparam logic [7:0] hs_min_clocks = 8'h15;
	localparam logic [7:0] lp_min_clocks = 8'h12;
	localparam logic osc_high_speed = 1'b0;
	localparam logic osc_low_power = 1'b1;
	localparam logic [1:0] err_disabled = 2'h0;
	localparam logic [1:0] err_enabled_ok = 2'h1;
	localparam logic [1:0] err_enabled_fault = 2'h3;
	localparam logic [1:0] layout_pad_a = 2'h0;
	localparam logic [1:0] layout_tag = 2'h1;
	localparam logic [1:0] layout_tag_valid = 2'h2;
	localparam logic [1:0] layout_pad_b = 2'h3;
	localparam logic [2:0] fill_stop_burst = 3'h0;
	localparam logic [2:0] fill_start_burst = 3'h1;
	localparam logic [2:0] fill_pre_alert = 3'h4;
	localparam logic [2:0] fill_post_alert = 3'h6;
	typedef enum logic {seq_idle, seq_busy} seq_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic [11:0] result;
		logic chan;
		logic valid_flag;
		logic stb;
	} sample_t;
endpackage

// ---- hw/scan_timing_buffer_ctrl_regs.sv ----
// How it works
// - cancel write stops conversion, activity pin low
// - status clears on resets and scan launch
// - error state bits 2-1, codes 00/01/11
// - status reserved bits read zero
// - oscillator choice 0 high-speed, 1 low-power
// - eight-bit clocks per conversion cycle
// - high-speed clamps cycle clocks to 21 minimum
// - low-power clamps cycle clocks to 18 minimum
// - three-bit buffer fill policy, default burst start
// - word layout field picks buffer word content
// - layout codes pad, tag, tag plus valid
// - launch write raises activity pin, starts conversion
`timescale 1ns/1ps
`default_nettype none
module scan_timing_buffer_ctrl_regs
	import scan_regs_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic gc_reset,
	input wire logic dev_reset,
	input wire reg_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic osc_tick,
	input wire logic autoseq_en,
	input wire logic seq_fault,
	input wire sample_t sample,
	output logic busy_pin,
	output logic conv_start,
	output logic conv_done,
	output logic osc_select,
	output logic [7:0] cycle_clocks_eff,
	output logic [2:0] fill_policy,
	output logic [15:0] buf_word,
	output logic buf_word_stb
);
	logic soft_clr;
	logic wr_launch, wr_cancel;
	logic osc_q;
	logic [7:0] conversion_cycle_clocks_q;
	logic [7:0] conversion_cycle_clocks_min;
	logic [1:0] layout_q;
	logic [2:0] fill_q;
	logic [1:0] err_q;
	logic [1:0] err_d;
	seq_state_t state_q;
	logic [7:0] cnt_q;
	logic last_tick;
	logic [7:0] rdata_q;
	logic rvalid_q;
	logic start_q, done_q;
	logic [15:0] word_q;
	logic word_stb_q;
	logic [7:0] rd_mux;

	assign soft_clr = gc_reset | dev_reset;
	assign wr_launch = req.wr && req.addr == scan_launch_off
		&& req.wdata[launch_bit];
	assign wr_cancel = req.wr && req.addr == scan_cancel_off
		&& req.wdata[cancel_bit];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_q <= oscillator_choice_rst[osc_bit];
			conversion_cycle_clocks_q <= conv_cycle_clocks_rst;
			layout_q <= word_layout_rst;
			fill_q <= buffer_fill_policy_rst;
		end else if (soft_clr) begin
			osc_q <= oscillator_choice_rst[osc_bit];
			conversion_cycle_clocks_q <= conv_cycle_clocks_rst;
			layout_q <= word_layout_rst;
			fill_q <= buffer_fill_policy_rst;
		end else if (req.wr) begin
			case (req.addr)
				oscillator_choice_off: osc_q <= req.wdata[osc_bit];
				// raw clock count kept as written
				conv_cycle_clocks_off: conversion_cycle_clocks_q <= req.wdata;
				word_layout_off: layout_q <= req.wdata[1:0];
				// reserved codes are stored as written
				buffer_fill_policy_off: fill_q <= req.wdata[2:0];
				default: ;
			endcase
		end
	end

	// oscillator floor, low-power or high-speed
	// clamp follows the live oscillator, so a later switch re-applies it
	assign conversion_cycle_clocks_min = (osc_q == osc_low_power) ? lp_min_clocks
		: hs_min_clocks;
	assign cycle_clocks_eff = (conversion_cycle_clocks_q <= conversion_cycle_clocks_min) ? conversion_cycle_clocks_min : conversion_cycle_clocks_q;

	always_comb begin
		if (!autoseq_en)
			err_d = err_disabled;
		else if (seq_fault)
			err_d = err_enabled_fault;
		else
			err_d = err_enabled_ok;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			err_q <= err_disabled;
		else if (soft_clr || wr_launch)
			err_q <= err_disabled;
		else
			err_q <= err_d;
	end

	assign last_tick = osc_tick && (cnt_q == cycle_clocks_eff - 8'h01);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= seq_idle;
			cnt_q <= zero_byte;
			start_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			done_q <= 1'b0;
			if (soft_clr) begin
				state_q <= seq_idle;
				cnt_q <= zero_byte;
			end else if (wr_cancel) begin
				state_q <= seq_idle;
				cnt_q <= zero_byte;
			end else if (wr_launch) begin
				state_q <= seq_busy;
				cnt_q <= zero_byte;
				start_q <= 1'b1;
			end else begin
				case (state_q)
					seq_idle: ;
					seq_busy: begin
						// one cycle is eff ticks long
						if (last_tick) begin
							cnt_q <= zero_byte;
							done_q <= 1'b1;
							start_q <= 1'b1;
						end else if (osc_tick) begin
							cnt_q <= cnt_q + 8'h01;
						end
					end
					default: state_q <= seq_idle;
				endcase
			end
		end
	end

	always_comb begin
		rd_mux = zero_byte;
		case (req.addr)
			scan_error_state_off: rd_mux[err_lo +: 2] = err_q;
			oscillator_choice_off: rd_mux[osc_bit] = osc_q;
			conv_cycle_clocks_off: rd_mux = conversion_cycle_clocks_q;
			word_layout_off: rd_mux[1:0] = layout_q;
			buffer_fill_policy_off: rd_mux[2:0] = fill_q;
			default: rd_mux = zero_byte;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= zero_byte;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
			if (req.rd)
				rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			word_q <= 16'h0000;
			word_stb_q <= 1'b0;
		end else begin
			word_stb_q <= sample.stb;
			if (sample.stb) begin
				case (layout_q)
					layout_tag:
						word_q <= {sample.result, 2'h0, sample.chan, 1'b0};
					layout_tag_valid:
						word_q <= {sample.result, 2'h0, sample.chan,
							sample.valid_flag};
					default: word_q <= {sample.result, 4'h0};
				endcase
			end
		end
	end

	assign rdata = rdata_q;
	assign rvalid = rvalid_q;
	assign busy_pin = (state_q == seq_busy);
	assign conv_start = start_q;
	assign conv_done = done_q;
	assign osc_select = osc_q;
	assign fill_policy = fill_q;
	assign buf_word = word_q;
	assign buf_word_stb = word_stb_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence launch_s;
		wr_launch && !soft_clr && !wr_cancel;
	endsequence
	sequence cancel_s;
		wr_cancel && !soft_clr;
	endsequence

	cancel_drops_busy_a: assert property (cancel_s |=> !busy_pin)
		else $error("busy stayed high after cancel");
	status_clear_a: assert property ((soft_clr || wr_launch) |=>
		err_q == err_disabled)
		else $error("status not cleared");
	error_code_a: assert property (!soft_clr && !wr_launch && autoseq_en
		&& seq_fault |=> err_q == err_enabled_fault)
		else $error("fault code wrong");
	reserved_zero_a: assert property (req.rd && req.addr ==
		scan_error_state_off |=> rdata[7:3] == 5'h00 && !rdata[0])
		else $error("status reserved bits set");
	hs_floor_a: assert property (osc_q == osc_high_speed && conversion_cycle_clocks_q <=
		hs_min_clocks |-> cycle_clocks_eff == hs_min_clocks)
		else $error("high-speed floor broken");
	lp_floor_a: assert property (osc_q == osc_low_power && conversion_cycle_clocks_q >
		lp_min_clocks |-> cycle_clocks_eff == conversion_cycle_clocks_q)
		else $error("low-power pass-through broken");
	layout_tag_a: assert property (sample.stb && layout_q == layout_tag
		|=> buf_word[3:0] == {2'h0, $past(sample.chan), 1'b0})
		else $error("tag layout wrong");
	launch_busy_a: assert property (launch_s |=> busy_pin && conv_start)
		else $error("launch did not start");
	cancel_read_a: assert property (req.rd && req.addr == scan_cancel_off
		|=> rvalid && rdata == zero_byte)
		else $error("cancel reads nonzero");
	fill_write_a: assert property (req.wr && !soft_clr && req.addr ==
		buffer_fill_policy_off |=> fill_policy == $past(req.wdata[2:0]))
		else $error("fill policy not stored");
endmodule // scan_timing_buffer_ctrl_regs
`default_nettype wire
